// *** design/acmp_ctrl.sv ***
// Analog comparator control and status logic with Wishbone slave
module acmp_ctrl
  import acmp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [9:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Analog core
  input  wire logic       cmp_raw_i,
  output logic            comparator_power_off_o,
  output logic            bandgap_positive_select_o,
  output logic            neg_mux_active_o,
  output logic      [2:0] neg_channel_o,
  // Converter and cpu context
  input  wire logic       converter_on_i,
  input  wire logic       converter_power_reduction_i,
  input  wire logic [2:0] channel_select_i,
  input  wire logic       global_irq_enable_i,
  input  wire logic       vector_taken_i,
  // Timer capture and interrupts
  output logic            capture_o,
  output logic            cmp_irq_o,
  output logic            irq_o
);
  // ****************************************
  // Synchroniser and edge detection
  // ****************************************
  logic       sync_a;
  logic       sync_b;
  logic       prev_b;
  logic       ev_rise;
  logic       ev_fall;
  logic       ev_hit;
  logic [7:0] csb;
  logic [7:0] cs;
  logic [1:0] mode;
  logic       flag;
  logic [1:0] stat;
  logic [1:0] mask;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
    end else begin
      sync_a <= cmp_raw_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_b <= 1'b0;
    end else begin
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_b <= 1'b0;
    end else begin
      prev_b <= sync_b;
    end
  end

  assign mode    = cs[ACMP_B_MODE_HI:ACMP_B_MODE_LO];
  assign ev_rise = sync_b & ~prev_b;
  assign ev_fall = ~sync_b & prev_b;
  assign ev_hit  = (mode == ACMP_MODE_TOGGLE) ? (ev_rise | ev_fall) :
                   (mode == ACMP_MODE_FALL)   ? ev_fall :
                   (mode == ACMP_MODE_RISE)   ? ev_rise : 1'b0;
  // ****************************************
  // Bus decode
  // ****************************************
  logic       req;
  logic       wr;
  logic       rd;
  logic       hit_csb;
  logic       hit_cs;
  logic       hit_stat;
  logic       hit_mask;
  logic [7:0] rd_byte;
  logic       clr_flag;
  logic       rd_stat;
  assign req      = cyc_i & stb_i & ~ack_o;
  assign wr       = req & we_i & sel_i[0];
  assign rd       = req & ~we_i;
  assign hit_csb  = adr_i == ACMP_ADR_CONV_CSB;
  assign hit_cs   = adr_i == ACMP_ADR_CMP_CS;
  assign hit_stat = adr_i == ACMP_ADR_IRQ_STAT;
  assign hit_mask = adr_i == ACMP_ADR_IRQ_MASK;
  assign clr_flag = (wr & hit_cs & dat_i[ACMP_B_FLAG]) | vector_taken_i;
  assign rd_stat  = rd & hit_stat;
  assign rd_byte  = hit_csb  ? (csb & 8'h47) :
                    hit_cs   ? {cs[7:6], sync_b, flag, cs[3:0]} :
                    hit_stat ? {6'h00, stat} :
                    hit_mask ? {6'h00, mask} : 8'h00;
  // ****************************************
  // Next values
  // ****************************************
  logic [7:0]  next_csb;
  logic [7:0]  next_cs;
  logic [1:0]  next_mask;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        next_flag;
  logic [1:0]  next_stat;
  logic [1:0]  stat_set;
  logic        mux_ok;
  logic        next_pwr_off;
  logic        next_bandgap;
  logic        next_mux_active;
  logic [2:0]  next_channel;
  logic        next_capture;
  logic        next_cmp_irq;
  logic        next_irq;

  assign next_ack        = req;
  assign next_dat        = rd ? {24'h0, rd_byte} : 32'h0;
  assign next_csb        = (wr & hit_csb) ? (dat_i[7:0] & 8'h47) : csb;
  assign next_cs         = (wr & hit_cs) ? {dat_i[7:6], 2'b00, dat_i[3:0]} : cs;
  assign next_mask       = (wr & hit_mask) ? dat_i[1:0] : mask;
  assign next_flag       = ev_hit | (flag & ~clr_flag);
  assign stat_set        = {ev_hit & cs[ACMP_B_CAPT], ev_hit};
  assign mux_ok          = csb[ACMP_B_MUX_EN] & ~converter_on_i
                           & ~converter_power_reduction_i;
  assign next_pwr_off    = cs[ACMP_B_PWR_OFF];
  assign next_bandgap    = cs[ACMP_B_BANDGAP];
  assign next_mux_active = mux_ok;
  assign next_channel    = mux_ok ? channel_select_i : 3'h0;
  assign next_capture    = cs[ACMP_B_CAPT] & sync_b;
  assign next_cmp_irq    = next_flag & cs[ACMP_B_IRQ_EN]
                           & global_irq_enable_i;
  assign next_irq        = |(stat & mask);

  // Sticky status bits, set wins over read clear
  for (genvar g = 0; g < 2; g++) begin : g_stat
    assign next_stat[g] = stat_set[g] | (stat[g] & ~rd_stat);
  end

  // ****************************************
  // Bus acknowledge
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= next_ack;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else begin
      dat_o <= next_dat;
    end
  end

  // ****************************************
  // Converter control register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csb <= ACMP_RST_CONV_CSB;
    end else begin
      csb <= next_csb;
    end
  end

  // ****************************************
  // Comparator control register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs <= ACMP_RST_CMP_CS;
    end else begin
      cs <= next_cs;
    end
  end

  // ****************************************
  // Interrupt mask register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= ACMP_RST_IRQ_MASK;
    end else begin
      mask <= next_mask;
    end
  end

  // ****************************************
  // Event flag
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= ACMP_RST_IRQ_STAT;
    end else begin
      stat <= next_stat;
    end
  end

  // ****************************************
  // Power control
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_power_off_o <= 1'b0;
    end else begin
      comparator_power_off_o <= next_pwr_off;
    end
  end

  // ****************************************
  // Positive input select
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bandgap_positive_select_o <= 1'b0;
    end else begin
      bandgap_positive_select_o <= next_bandgap;
    end
  end

  // ****************************************
  // Negative input mux
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      neg_mux_active_o <= 1'b0;
    end else begin
      neg_mux_active_o <= next_mux_active;
    end
  end

  // ****************************************
  // Negative input channel
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      neg_channel_o <= 3'h0;
    end else begin
      neg_channel_o <= next_channel;
    end
  end

  // ****************************************
  // Timer capture route
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_o <= 1'b0;
    end else begin
      capture_o <= next_capture;
    end
  end

  // ****************************************
  // Comparator request
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_irq_o <= 1'b0;
    end else begin
      cmp_irq_o <= next_cmp_irq;
    end
  end

  // ****************************************
  // Level interrupt
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

endmodule : acmp_ctrl

// *** design/acmp_pkg.sv ***
// Constants for the analog comparator control block
// How it works
// - Raw comparator output double-synchronised to status
// - Channel select drives negative input when allowed
// - Bandgap select replaces positive pin input
// - Power-off bit powers comparator down
// - Selected output event sets event flag
// - Mode 00 toggle, 10 fall, 11 rise
// - Flag cleared by vector taken or write-one
// - Request needs flag, enable, global enable
// - Capture route enable feeds timer capture
// - Mux usable only without converter power reduction
// - Converter on blocks negative mux override
package acmp_pkg;
  // ****************************************
  // Register map (byte addresses = index*4)
  // ****************************************
  localparam logic [7:0] ACMP_IDX_CONV_CSB  = 8'h7b;
  localparam logic [7:0] ACMP_IDX_CMP_CS    = 8'h50;
  localparam logic [7:0] ACMP_IDX_IRQ_STAT  = 8'h51;
  localparam logic [7:0] ACMP_IDX_IRQ_MASK  = 8'h52;
  localparam logic [9:0] ACMP_ADR_CONV_CSB  = {ACMP_IDX_CONV_CSB, 2'b00};
  localparam logic [9:0] ACMP_ADR_CMP_CS    = {ACMP_IDX_CMP_CS, 2'b00};
  localparam logic [9:0] ACMP_ADR_IRQ_STAT  = {ACMP_IDX_IRQ_STAT, 2'b00};
  localparam logic [9:0] ACMP_ADR_IRQ_MASK  = {ACMP_IDX_IRQ_MASK, 2'b00};
  // ****************************************
  // Field positions
  // ****************************************
  localparam int ACMP_B_MUX_EN   = 6;
  localparam int ACMP_B_PWR_OFF  = 7;
  localparam int ACMP_B_BANDGAP  = 6;
  localparam int ACMP_B_OUT      = 5;
  localparam int ACMP_B_FLAG     = 4;
  localparam int ACMP_B_IRQ_EN   = 3;
  localparam int ACMP_B_CAPT     = 2;
  localparam int ACMP_B_MODE_HI  = 1;
  localparam int ACMP_B_MODE_LO  = 0;
  // ****************************************
  // Reset values and modes
  // ****************************************
  localparam logic [7:0] ACMP_RST_CONV_CSB = 8'h00;
  localparam logic [7:0] ACMP_RST_CMP_CS   = 8'h00;
  localparam logic [1:0] ACMP_RST_IRQ_STAT = 2'h0;
  localparam logic [1:0] ACMP_RST_IRQ_MASK = 2'h0;
  localparam logic [1:0] ACMP_MODE_TOGGLE  = 2'h0;
  localparam logic [1:0] ACMP_MODE_FALL    = 2'h2;
  localparam logic [1:0] ACMP_MODE_RISE    = 2'h3;
endpackage : acmp_pkg

// *** tb/acmp_ctrl_chk.sv ***
// Port checker for the comparator control block
module acmp_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ack_o,
  input wire logic       we_i,
  input wire logic       cmp_raw_i,
  input wire logic       comparator_power_off_o,
  input wire logic       bandgap_positive_select_o,
  input wire logic       neg_mux_active_o,
  input wire logic [2:0] neg_channel_o,
  input wire logic       converter_on_i,
  input wire logic       converter_power_reduction_i,
  input wire logic       global_irq_enable_i,
  input wire logic       capture_o,
  input wire logic       cmp_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_sync; capture_o |-> $past(cmp_raw_i, 3); endproperty
  a_sync: assert property (p_sync) else $error("capture early");
  property p_chan; !neg_mux_active_o |-> neg_channel_o == 3'h0; endproperty
  a_chan: assert property (p_chan) else $error("channel leak");
  property p_conv; $past(converter_on_i) |-> !neg_mux_active_o; endproperty
  a_conv: assert property (p_conv) else $error("mux while on");
  property p_prd; $past(converter_power_reduction_i) |-> !neg_mux_active_o; endproperty
  a_prd: assert property (p_prd) else $error("mux while reduced");
  property p_pwr; $changed(comparator_power_off_o) |-> $past(ack_o) && $past(we_i); endproperty
  a_pwr: assert property (p_pwr) else $error("power bit moved");
  property p_bg; $changed(bandgap_positive_select_o) |-> $past(ack_o) && $past(we_i); endproperty
  a_bg: assert property (p_bg) else $error("bandgap bit moved");
  property p_glb; cmp_irq_o |-> $past(global_irq_enable_i); endproperty
  a_glb: assert property (p_glb) else $error("request no global");
  property p_ack; ack_o |=> !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
endmodule : acmp_ctrl_chk
bind acmp_ctrl acmp_ctrl_chk u_chk (.*);

// *** tb/acmp_core_model.sv ***
// Behavioural analog core facing the comparator control block
module acmp_core_model (
  input wire logic off_i,
  input wire logic bg_sel_i,
  input wire logic pin_hi_i,
  input wire logic bg_hi_i,
  output logic     raw_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unpowered core holds its output low
  assign raw_o = !off_i && (bg_sel_i ? bg_hi_i : pin_hi_i);
endmodule : acmp_core_model

// *** tb/test_analog_comparator_control.sv ***
// Self-checking bench for the comparator control block
module test_analog_comparator_control
  import acmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, vector_taken_i = 0;
  logic converter_on_i = 0, converter_power_reduction_i = 0, global_irq_enable_i = 0;
  logic pin_hi = 0, bg_hi = 0, cmp_raw_i, ack_o, comparator_power_off_o;
  logic bandgap_positive_select_o, neg_mux_active_o, capture_o, cmp_irq_o, irq_o;
  logic [9:0]  adr_i = 0;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 0, dat_o;
  logic [2:0]  channel_select_i = 3'h5, neg_channel_o;
  logic [7:0]  q;
  logic [3:0]  rise = 4'b1001, fall = 4'b1101;
  int bad_count = 0, n_compared = 0;
  acmp_ctrl u_dut (.*);
  acmp_core_model u_core (.off_i(comparator_power_off_o), .bg_sel_i(bandgap_positive_select_o),
    .pin_hi_i(pin_hi), .bg_hi_i(bg_hi), .raw_o(cmp_raw_i));
  initial forever #25 clk_i = ~clk_i;
  task automatic results;
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    if (ack_o !== 1'b1) begin bad_count++; results(); end
  endtask : wb
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input string n);
    wb(1'b0, a, 8'h00);
    chk(q, e, n);
  endtask : rd
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rd(ACMP_ADR_CMP_CS, 8'h00, "cs reset");
    rd(ACMP_ADR_CONV_CSB, 8'h00, "csb reset");
    wb(1, 10'h3fc, 8'hff);
    rd(10'h3fc, 8'h00, "unmapped");
    wb(1, ACMP_ADR_CONV_CSB, 8'hff);
    rd(ACMP_ADR_CONV_CSB, 8'h47, "csb");
    chk({4'h0, neg_mux_active_o, neg_channel_o}, 8'h0d, "mux");
    converter_on_i <= 1;
    repeat (2) @(posedge clk_i);
    chk(neg_mux_active_o, 8'h00, "conv on");
    converter_on_i <= 0;
    converter_power_reduction_i <= 1;
    repeat (2) @(posedge clk_i);
    chk(neg_mux_active_o, 8'h00, "reduced");
    converter_power_reduction_i <= 0;
    for (int i = 0; i < 4; i++) begin
      wb(1, ACMP_ADR_CMP_CS, 8'h10 | 8'(i));
      pin_hi <= 1;
      repeat (6) @(posedge clk_i);
      rd(ACMP_ADR_CMP_CS, {3'b001, rise[i], 2'b00, 2'(i)}, "rise");
      pin_hi <= 0;
      repeat (6) @(posedge clk_i);
      rd(ACMP_ADR_CMP_CS, {3'b000, fall[i], 2'b00, 2'(i)}, "fall");
    end
    rd(ACMP_ADR_IRQ_STAT, 8'h01, "status");
    wb(1, ACMP_ADR_CMP_CS, 8'h10);
    wb(1, ACMP_ADR_CMP_CS, 8'h18);
    pin_hi <= 1;
    repeat (6) @(posedge clk_i);
    chk({cmp_irq_o, irq_o}, 8'h00, "no global");
    global_irq_enable_i <= 1;
    repeat (2) @(posedge clk_i);
    chk(cmp_irq_o, 8'h01, "request");
    vector_taken_i <= 1;
    @(posedge clk_i);
    vector_taken_i <= 0;
    repeat (2) @(posedge clk_i);
    chk(cmp_irq_o, 8'h00, "vector");
    rd(ACMP_ADR_CMP_CS, 8'h28, "flag clear");
    wb(1, ACMP_ADR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 8'h01, "irq");
    rd(ACMP_ADR_IRQ_STAT, 8'h01, "status");
    repeat (2) @(posedge clk_i);
    chk(irq_o, 8'h00, "irq clear");
    wb(1, ACMP_ADR_CMP_CS, 8'h00);
    wb(1, ACMP_ADR_CMP_CS, 8'h05);
    repeat (4) @(posedge clk_i);
    chk(capture_o, 8'h01, "capture");
    wb(1, ACMP_ADR_CMP_CS, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(capture_o, 8'h00, "no capture");
    pin_hi <= 0;
    bg_hi <= 1;
    wb(1, ACMP_ADR_CMP_CS, 8'h41);
    repeat (6) @(posedge clk_i);
    rd(ACMP_ADR_CMP_CS, 8'h61, "bandgap");
    chk(bandgap_positive_select_o, 8'h01, "bandgap pin");
    wb(1, ACMP_ADR_CMP_CS, 8'hc1);
    repeat (6) @(posedge clk_i);
    rd(ACMP_ADR_CMP_CS, 8'hc1, "power off");
    chk(comparator_power_off_o, 8'h01, "power pin");
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule : test_analog_comparator_control
